/* File: ucc_top.sv */
// two-channel serial controller: mode pointer, clock select, command decode, register slave
// How it works
// - reset or pointer-reset command points the mode pointer at the first mode register
// - any access to the first mode register moves the pointer to the second
// - accesses to the second mode register leave the pointer where it is
// - channel B uses the same mode register meanings for its own engines
// - rate-set bit of aux control picks which of two rate tables codes index
// - receiver clock is 16x selected rate; code 1111 takes an external 1x clock
// - transmitter clock is 16x selected rate; code 1111 takes an external 1x clock
// - channel A receiver clock code 111x takes its clock from parallel input four
// - channel A transmitter clock code 111x takes its clock from parallel input three
// - channel B receiver clock code 111x takes its clock from parallel input two
// - channel B transmitter clock code 111x takes its clock from parallel input five
// - all commands in one command write are executed; host avoids conflicting ones
// - top bit of a command write is ignored
// - misc code 000 does nothing, 001 resets the mode pointer
// - code 010 disables receiver now, clears ready and full, resets queue pointer
// - code 011 disables transmitter now and clears its ready and empty status
// - code 100 clears break, parity, framing and overrun flags of the status
// - code 101 clears the channel break-change bit of irq status
// - code 110 forces serial out low after current and held characters finish
// - code 111 releases break within two bit times, then one bit of mark
// - transmitter field 01 enables; 10 disables after the current character ends
// - receiver field 10 stops at once, dropping partial characters; 01 enables
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`default_nettype none

module ucc_chan
    import ucc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic acr_set,
    input wire logic ext_rx,
    input wire logic ext_tx,
    input wire logic wr_mode,
    input wire logic wr_csel,
    input wire logic wr_cmd,
    input wire logic acc_mode,
    input wire logic [7:0] wdata,
    input wire ucc_pkg::ucc_evt_s evt,
    output ucc_pkg::ucc_ctl_s ctl,
    output logic [7:0] mode_rdata,
    output logic [7:0] status,
    output logic brk_change
);
    ucc_chan_st_s s;
    ucc_chan_st_s next_s;
    ucc_cmd_s cmd;
    logic clr_err;
    logic clr_brk;
    logic brk_start;
    logic brk_stop;
    logic bit_end;

    assign cmd = ucc_cmd_s'(wdata); // cmd.unused is never read
    assign clr_err = wr_cmd && cmd.misc == UCC_MISC_ERR_RST;
    assign clr_brk = wr_cmd && cmd.misc == UCC_MISC_BRK_CLR;
    assign brk_start = wr_cmd && cmd.misc == UCC_MISC_BRK_START;
    assign brk_stop = wr_cmd && cmd.misc == UCC_MISC_BRK_STOP;
    assign bit_end = s.tx_tick && (s.csel.tx_code == UCC_EXT_X1 || s.bit_cnt == UCC_BIT_LAST);

    always_comb begin
        next_s = s;
        next_s.rx_flush = 1'b0;
        next_s.rx_qrst = 1'b0;
        // 16x from the divider or a synced rising pin edge; 1x codes count each rising edge as a bit
        {next_s.rx_tick, next_s.rx_div} = ucc_tick_step(s.csel.rx_code[3:1] == UCC_EXT_PREFIX,
            ext_rx, s.rx_ext_d, s.rx_div, ucc_reload(acr_set, s.csel.rx_code));
        {next_s.tx_tick, next_s.tx_div} = ucc_tick_step(s.csel.tx_code[3:1] == UCC_EXT_PREFIX,
            ext_tx, s.tx_ext_d, s.tx_div, ucc_reload(acr_set, s.csel.tx_code));
        next_s.rx_ext_d = ext_rx;
        next_s.tx_ext_d = ext_tx;
        if (s.tx_tick) begin
            next_s.bit_cnt = bit_end ? 5'h00 : 5'(s.bit_cnt + 5'h01);
        end
        // engine events win over a clear in the same cycle
        next_s.errs = (s.errs & ~{4{clr_err}}) | evt.err_set;
        next_s.brk_chg = (s.brk_chg & ~clr_brk) | evt.break_change;
        if (s.tx_dis_pend && !evt.tx_busy) begin
            next_s.tx_en = 1'b0;
            next_s.tx_dis_pend = 1'b0;
        end
        if (wr_mode) begin
            if (s.ptr_second) begin
                next_s.mode_second = wdata;
            end else begin
                next_s.mode_first = wdata;
            end
        end
        if (acc_mode) begin
            next_s.ptr_second = 1'b1;
        end
        if (wr_csel) begin
            next_s.csel = ucc_csel_s'(wdata);
        end
        if (wr_cmd) begin
            // every field of the word acts; misc resets come last and win
            if (cmd.rx == UCC_TRX_EN) begin
                next_s.rx_en = 1'b1;
            end else if (cmd.rx == UCC_TRX_DIS) begin
                next_s.rx_en = 1'b0;
                next_s.rx_flush = 1'b1;
            end
            if (cmd.tx == UCC_TRX_EN) begin
                next_s.tx_en = 1'b1;
                next_s.tx_dis_pend = 1'b0;
            end else if (cmd.tx == UCC_TRX_DIS) begin
                if (evt.tx_busy) begin
                    next_s.tx_dis_pend = 1'b1;
                end else begin
                    next_s.tx_en = 1'b0;
                end
            end
            unique case (cmd.misc)
                UCC_MISC_NONE: begin
                end
                UCC_MISC_PTR_RST: begin
                    next_s.ptr_second = 1'b0;
                end
                UCC_MISC_RX_RST: begin
                    next_s.rx_en = 1'b0;
                    next_s.rx_flush = 1'b1;
                    next_s.rx_qrst = 1'b1;
                end
                UCC_MISC_TX_RST: begin
                    next_s.tx_en = 1'b0;
                    next_s.tx_dis_pend = 1'b0;
                end
                UCC_MISC_ERR_RST: begin
                end
                UCC_MISC_BRK_CLR: begin
                end
                UCC_MISC_BRK_START: begin
                end
                UCC_MISC_BRK_STOP: begin
                end
            endcase
        end
        unique case (s.brk)
            UCC_BRK_IDLE: begin
                if (brk_start) begin
                    next_s.brk = UCC_BRK_WAIT;
                end
            end
            UCC_BRK_WAIT: begin
                // busy covers the shifting and the held character
                if (brk_stop) begin
                    next_s.brk = UCC_BRK_IDLE;
                end else if (!evt.tx_busy) begin
                    next_s.brk = UCC_BRK_DELAY;
                    next_s.bit_cnt = 5'h00;
                end
            end
            UCC_BRK_DELAY: begin
                if (brk_stop) begin
                    next_s.brk = UCC_BRK_IDLE;
                end else if (bit_end) begin
                    next_s.brk = UCC_BRK_ON;
                end
            end
            UCC_BRK_ON: begin
                if (brk_stop) begin
                    next_s.brk = UCC_BRK_MARK;
                    next_s.bit_cnt = 5'h00;
                end
            end
            UCC_BRK_MARK: begin
                // one full bit of mark before the next character
                if (bit_end) begin
                    next_s.brk = UCC_BRK_IDLE;
                end else if (brk_start) begin
                    next_s.brk = UCC_BRK_WAIT;
                end
            end
            default: begin
                next_s.brk = UCC_BRK_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= UCC_CHAN_RST;
        end else begin
            s <= next_s;
        end
    end

    always_comb begin
        ctl.rx_en = s.rx_en;
        ctl.tx_en = s.tx_en;
        ctl.rx_flush = s.rx_flush;
        ctl.rx_queue_reset = s.rx_qrst;
        ctl.rx_tick = s.rx_tick;
        ctl.tx_tick = s.tx_tick;
        ctl.rx_ext = s.csel.rx_code[3:1] == UCC_EXT_PREFIX;
        ctl.tx_ext = s.csel.tx_code[3:1] == UCC_EXT_PREFIX;
        ctl.rx_x1 = s.csel.rx_code == UCC_EXT_X1;
        ctl.tx_x1 = s.csel.tx_code == UCC_EXT_X1;
        ctl.tx_break = s.brk == UCC_BRK_ON;
        ctl.tx_mark_hold = s.brk == UCC_BRK_MARK;
        ctl.mode_first = s.mode_first;
        ctl.mode_second = s.mode_second;
    end

    assign mode_rdata = s.ptr_second ? s.mode_second : s.mode_first;
    // tx ready and empty are only live while the transmitter is enabled; a queue reset masks rx ready and full for one cycle
    assign status = {s.errs, evt.tx_all_empty & s.tx_en, evt.tx_hold_free & s.tx_en,
        evt.rx_queue_full & ~s.rx_qrst, evt.rx_char_avail & ~s.rx_qrst};
    assign brk_change = s.brk_chg;
endmodule

module ucc_top
    import ucc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ucc_pkg::UCC_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ucc_pkg::UCC_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic par_in_two,
    input wire logic par_in_three,
    input wire logic par_in_four,
    input wire logic par_in_five,
    input wire ucc_pkg::ucc_evt_s evt_a,
    input wire ucc_pkg::ucc_evt_s evt_b,
    output ucc_pkg::ucc_ctl_s ctl_a,
    output ucc_pkg::ucc_ctl_s ctl_b
);
    ucc_top_st_s s;
    ucc_top_st_s next_s;
    ucc_addr_s wa;
    ucc_addr_s ra;
    logic wr_take;
    logic rd_take;
    logic wr_lane;
    logic wr_ch;
    logic rd_ch;
    logic [1:0] wr_mode;
    logic [1:0] wr_csel;
    logic [1:0] wr_cmd;
    logic [1:0] acc_mode;
    logic [7:0] mode_rd [2];
    logic [7:0] stat [2];
    logic [1:0] brk_chg;
    logic [7:0] irq_status;

    assign wa = ucc_addr_s'(awaddr);
    assign ra = ucc_addr_s'(araddr);
    // one write and one read at a time; a write wins the cycle so the pointer moves once
    assign wr_take = awvalid && wvalid && !s.bvalid;
    assign rd_take = arvalid && !s.rvalid && !wr_take;
    assign awready = wr_take;
    assign wready = wr_take;
    assign arready = rd_take;
    assign wr_lane = wr_take && wstrb[0];
    assign wr_ch = wa.region == UCC_REGION_CHAN;
    assign rd_ch = ra.region == UCC_REGION_CHAN;

    always_comb begin
        irq_status = 8'h00;
        irq_status[UCC_IRQ_BRK_A] = brk_chg[UCC_CH_A];
        irq_status[UCC_IRQ_BRK_B] = brk_chg[UCC_CH_B];
        for (int i = 0; i < 2; i++) begin
            wr_mode[i] = wr_lane && wr_ch && wa.chan == 1'(i) && wa.ofs == UCC_OFS_MODE;
            wr_csel[i] = wr_lane && wr_ch && wa.chan == 1'(i) && wa.ofs == UCC_OFS_CSEL;
            wr_cmd[i] = wr_lane && wr_ch && wa.chan == 1'(i) && wa.ofs == UCC_OFS_CMD;
            acc_mode[i] = wr_mode[i] ||
                (rd_take && rd_ch && ra.chan == 1'(i) && ra.ofs == UCC_OFS_MODE);
        end
    end

    always_comb begin
        next_s = s;
        // pins cross in two flops before any logic looks at them
        next_s.sync1 = {par_in_five, par_in_four, par_in_three, par_in_two};
        next_s.sync2 = s.sync1;
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (wr_take) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = UCC_RESP_OKAY;
            if (awaddr == UCC_ADDR_AUX) begin
                if (wstrb[0]) begin
                    next_s.aux = wdata[7:0];
                end
            end else if (!(wr_ch || awaddr == UCC_ADDR_IRQ)) begin
                next_s.bresp = UCC_RESP_SLVERR;
            end
        end
        if (rd_take) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = UCC_RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (rd_ch) begin
                if (ra.ofs == UCC_OFS_MODE) begin
                    next_s.rdata[7:0] = mode_rd[ra.chan];
                end else if (ra.ofs == UCC_OFS_STAT) begin
                    next_s.rdata[7:0] = stat[ra.chan];
                end else if (ra.ofs != UCC_OFS_CSEL && ra.ofs != UCC_OFS_CMD) begin
                    next_s.rresp = UCC_RESP_SLVERR;
                end
            end else if (araddr == UCC_ADDR_AUX) begin
                next_s.rdata[7:0] = s.aux;
            end else if (araddr == UCC_ADDR_IRQ) begin
                next_s.rdata[7:0] = irq_status;
            end else begin
                next_s.rresp = UCC_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= UCC_TOP_RST;
        end else begin
            s <= next_s;
        end
    end

    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rresp = s.rresp;
    assign rdata = s.rdata;

    ucc_chan u_chan_a (
        .aclk(aclk),
        .aresetn(aresetn),
        .acr_set(s.aux[UCC_AUX_SET_BIT]),
        .ext_rx(s.sync2[UCC_PIN_FOUR]),
        .ext_tx(s.sync2[UCC_PIN_THREE]),
        .wr_mode(wr_mode[UCC_CH_A]),
        .wr_csel(wr_csel[UCC_CH_A]),
        .wr_cmd(wr_cmd[UCC_CH_A]),
        .acc_mode(acc_mode[UCC_CH_A]),
        .wdata(wdata[7:0]),
        .evt(evt_a),
        .ctl(ctl_a),
        .mode_rdata(mode_rd[UCC_CH_A]),
        .status(stat[UCC_CH_A]),
        .brk_change(brk_chg[UCC_CH_A])
    );

    ucc_chan u_chan_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .acr_set(s.aux[UCC_AUX_SET_BIT]),
        .ext_rx(s.sync2[UCC_PIN_TWO]),
        .ext_tx(s.sync2[UCC_PIN_FIVE]),
        .wr_mode(wr_mode[UCC_CH_B]),
        .wr_csel(wr_csel[UCC_CH_B]),
        .wr_cmd(wr_cmd[UCC_CH_B]),
        .acc_mode(acc_mode[UCC_CH_B]),
        .wdata(wdata[7:0]),
        .evt(evt_b),
        .ctl(ctl_b),
        .mode_rdata(mode_rd[UCC_CH_B]),
        .status(stat[UCC_CH_B]),
        .brk_change(brk_chg[UCC_CH_B])
    );
endmodule
`default_nettype wire

/* File: ucc_pkg.sv */
// shared constants, types and helpers of the channel command and clock-select block
`default_nettype none
package ucc_pkg;
    localparam int UCC_AW = 8;
    // register map, byte addresses
    localparam logic [2:0] UCC_REGION_CHAN = 3'h0;
    localparam logic UCC_CH_A = 1'b0;
    localparam logic UCC_CH_B = 1'b1;
    localparam logic [3:0] UCC_OFS_MODE = 4'h0;
    localparam logic [3:0] UCC_OFS_CSEL = 4'h4;
    localparam logic [3:0] UCC_OFS_CMD = 4'h8;
    localparam logic [3:0] UCC_OFS_STAT = 4'hC;
    localparam logic [7:0] UCC_ADDR_AUX = 8'h20;
    localparam logic [7:0] UCC_ADDR_IRQ = 8'h24;
    localparam logic [1:0] UCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] UCC_RESP_SLVERR = 2'h2;
    // irq status bit of each channel's break change
    localparam int UCC_IRQ_BRK_A = 2;
    localparam int UCC_IRQ_BRK_B = 6;
    // parallel input sync vector positions
    localparam int UCC_PIN_TWO = 0;
    localparam int UCC_PIN_THREE = 1;
    localparam int UCC_PIN_FOUR = 2;
    localparam int UCC_PIN_FIVE = 3;
    localparam int UCC_NPIN = 4;
    // clock select codes
    localparam logic [2:0] UCC_EXT_PREFIX = 3'h7;
    localparam logic [3:0] UCC_EXT_X1 = 4'hF;
    localparam logic [4:0] UCC_BIT_LAST = 5'h0F;
    // aclk cycles per 16x tick at code 0, per rate set; shifted left by the code
    localparam logic [15:0] UCC_DIV_BASE0 = 16'h0003;
    localparam logic [15:0] UCC_DIV_BASE1 = 16'h0002;
    localparam logic [7:0] UCC_AUX_RST = 8'h00;
    localparam int UCC_AUX_SET_BIT = 7;
    // command fields
    localparam logic [1:0] UCC_TRX_EN = 2'h1;
    localparam logic [1:0] UCC_TRX_DIS = 2'h2;
    typedef enum logic [2:0] {
        UCC_MISC_NONE = 3'b000,
        UCC_MISC_PTR_RST = 3'b001,
        UCC_MISC_RX_RST = 3'b010,
        UCC_MISC_TX_RST = 3'b011,
        UCC_MISC_ERR_RST = 3'b100,
        UCC_MISC_BRK_CLR = 3'b101,
        UCC_MISC_BRK_START = 3'b110,
        UCC_MISC_BRK_STOP = 3'b111
    } ucc_misc_e;
    typedef struct packed {
        logic unused;
        ucc_misc_e misc;
        logic [1:0] tx;
        logic [1:0] rx;
    } ucc_cmd_s;
    typedef struct packed {
        logic [3:0] rx_code;
        logic [3:0] tx_code;
    } ucc_csel_s;
    typedef struct packed {
        logic [2:0] region;
        logic chan;
        logic [3:0] ofs;
    } ucc_addr_s;
    typedef enum logic [2:0] {
        UCC_BRK_IDLE = 3'b000,
        UCC_BRK_WAIT = 3'b001,
        UCC_BRK_DELAY = 3'b010,
        UCC_BRK_ON = 3'b011,
        UCC_BRK_MARK = 3'b100
    } ucc_brk_e;
    // levels and pulses from the serial engines of one channel
    typedef struct packed {
        logic tx_busy;
        logic tx_hold_free;
        logic tx_all_empty;
        logic rx_char_avail;
        logic rx_queue_full;
        logic [3:0] err_set;
        logic break_change;
    } ucc_evt_s;
    // controls to the serial engines of one channel
    typedef struct packed {
        logic rx_en;
        logic tx_en;
        logic rx_flush;
        logic rx_queue_reset;
        logic rx_tick;
        logic tx_tick;
        logic rx_ext;
        logic tx_ext;
        logic rx_x1;
        logic tx_x1;
        logic tx_break;
        logic tx_mark_hold;
        logic [7:0] mode_first;
        logic [7:0] mode_second;
    } ucc_ctl_s;
    typedef struct packed {
        logic [7:0] mode_first;
        logic [7:0] mode_second;
        logic ptr_second;
        ucc_csel_s csel;
        logic rx_en;
        logic tx_en;
        logic tx_dis_pend;
        logic [3:0] errs;
        logic brk_chg;
        logic [15:0] rx_div;
        logic [15:0] tx_div;
        logic rx_tick;
        logic tx_tick;
        logic rx_ext_d;
        logic tx_ext_d;
        ucc_brk_e brk;
        logic [4:0] bit_cnt;
        logic rx_qrst;
        logic rx_flush;
    } ucc_chan_st_s;
    localparam ucc_chan_st_s UCC_CHAN_RST = '0;
    typedef struct packed {
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] aux;
        logic [UCC_NPIN-1:0] sync1;
        logic [UCC_NPIN-1:0] sync2;
    } ucc_top_st_s;
    localparam ucc_top_st_s UCC_TOP_RST = '0;

    function automatic logic [15:0] ucc_reload(input logic set, input logic [3:0] code);
        logic [15:0] b;
        b = set ? UCC_DIV_BASE1 : UCC_DIV_BASE0;
        return (b << code) - 16'h0001;
    endfunction

    // returns {tick, next count}; external source ticks on each rising pin edge
    function automatic logic [16:0] ucc_tick_step(input logic ext_sel, input logic ext_now,
            input logic ext_last, input logic [15:0] cnt, input logic [15:0] reload);
        logic [16:0] r;
        if (ext_sel) begin
            r = {ext_now & ~ext_last, cnt};
        end else if (cnt == 16'h0000) begin
            r = {1'b1, reload};
        end else begin
            r = {1'b0, cnt - 16'h0001};
        end
        return r;
    endfunction
endpackage
`default_nettype wire

/* File: ucc_top_sva.sv */
// assertions on the command and clock-select ports of the block
`default_nettype none
module ucc_top_sva
    import ucc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ucc_pkg::UCC_AW-1:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    input wire ucc_pkg::ucc_ctl_s ctl_a,
    input wire ucc_pkg::ucc_ctl_s ctl_b
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr(logic [7:0] a);
        awvalid && awready && wvalid && wstrb[0] && awaddr == a;
    endsequence
    sequence s_cmd(logic [2:0] c);
        s_wr(8'h08) ##0 wdata[6:4] == c;
    endsequence
    property p_ext_a_rx;
        s_wr(8'h04) ##0 wdata[7:5] == 3'h7 |=> ctl_a.rx_ext;
    endproperty
    a_ext_a_rx: assert property (p_ext_a_rx) else $error("a rx pin clock");
    property p_ext_a_tx;
        s_wr(8'h04) ##0 wdata[3:1] == 3'h7 |=> ctl_a.tx_ext;
    endproperty
    a_ext_a_tx: assert property (p_ext_a_tx) else $error("a tx pin clock");
    property p_ext_b_rx;
        s_wr(8'h14) ##0 wdata[7:5] == 3'h7 |=> ctl_b.rx_ext;
    endproperty
    a_ext_b_rx: assert property (p_ext_b_rx) else $error("b rx pin clock");
    property p_ext_b_tx;
        s_wr(8'h14) ##0 wdata[3:0] == 4'hF |=> ctl_b.tx_ext && ctl_b.tx_x1;
    endproperty
    a_ext_b_tx: assert property (p_ext_b_tx) else $error("b tx 1x clock");
    property p_rx_rst;
        s_cmd(3'h2) |=> !ctl_a.rx_en && ctl_a.rx_queue_reset;
    endproperty
    a_rx_rst: assert property (p_rx_rst) else $error("rx reset");
    property p_tx_rst;
        s_cmd(3'h3) |=> !ctl_a.tx_en;
    endproperty
    a_tx_rst: assert property (p_tx_rst) else $error("tx reset");
    property p_rx_dis;
        s_wr(8'h08) ##0 wdata[1:0] == 2'h2 |=> !ctl_a.rx_en && ctl_a.rx_flush ##1 !ctl_a.rx_flush;
    endproperty
    a_rx_dis: assert property (p_rx_dis) else $error("rx disable");
    property p_brk_stop;
        s_cmd(3'h7) ##0 ctl_a.tx_break |=> !ctl_a.tx_break && ctl_a.tx_mark_hold;
    endproperty
    a_brk_stop: assert property (p_brk_stop) else $error("break stop");
endmodule
`default_nettype wire

/* File: ucc_eng_model.sv */
// serial engine stand-in that feeds channel events back to the block
`default_nettype none
module ucc_eng_model
    import ucc_pkg::*;
(
    input wire ucc_pkg::ucc_ctl_s ctl,
    input wire logic busy,
    input wire logic [3:0] err,
    input wire logic brk,
    output ucc_pkg::ucc_evt_s evt
);
    // busy holds off tx disable and break start until the character ends
    always_comb begin
        evt = '{tx_busy: busy, tx_hold_free: ctl.tx_en, tx_all_empty: ctl.tx_en & ~busy,
            rx_char_avail: 1'b0, rx_queue_full: 1'b0, err_set: err, break_change: brk};
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the command and clock-select block
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", n, e, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ucc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, busy = 1'b0, brk = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, d;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [3:0] wstrb = 4'hF, pin = 4'h0, err = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    ucc_evt_s evt_a, evt_b;
    ucc_ctl_s ctl_a, ctl_b;
    int checks = 0, mismatches = 0, nt = 0, g;
    ucc_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .par_in_two(pin[0]), .par_in_three(pin[1]), .par_in_four(pin[2]),
        .par_in_five(pin[3]), .evt_a(evt_a), .evt_b(evt_b), .ctl_a(ctl_a), .ctl_b(ctl_b));
    ucc_eng_model eng_a (.ctl(ctl_a), .busy(busy), .err(err), .brk(brk), .evt(evt_a));
    ucc_eng_model eng_b (.ctl(ctl_b), .busy(1'b0), .err(4'h0), .brk(1'b0), .evt(evt_b));
    initial begin
        forever #4 aclk = ~aclk;
    end
    always @(posedge aclk) if (ctl_a.rx_tick) nt <= nt + 1;
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        @(negedge aclk);
        while (!(awready && wready)) @(negedge aclk);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge aclk);
        while (!bvalid) @(negedge aclk);
        r = bresp;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        @(negedge aclk);
        while (!arready) @(negedge aclk);
        @(posedge aclk);
        arvalid <= 1'b0;
        @(negedge aclk);
        while (!rvalid) @(negedge aclk);
        d = rdata[7:0];
        r = rresp;
        @(posedge aclk);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
        rd(a);
        `CHK(n, e, d)
    endtask
    task automatic gap(output int n);
        @(negedge aclk iff ctl_a.rx_tick);
        @(negedge aclk iff ctl_a.rx_tick);
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (!ctl_a.rx_tick);
    endtask
    // the tests need a few hundred cycles; this leaves a wide margin
    initial begin
        #100000;
        mismatches++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        wr(8'h00, 8'h5A);
        wr(8'h00, 8'hA5);
        `CHK("mode_first", 8'h5A, ctl_a.mode_first)
        `CHK("mode_second", 8'hA5, ctl_a.mode_second)
        rc(8'h00, 8'hA5, "mode_ptr");
        wr(8'h08, 8'h00);
        rc(8'h00, 8'hA5, "mode_ptr");
        wr(8'h08, 8'h90);
        rc(8'h00, 8'h5A, "mode_ptr");
        rc(8'h00, 8'hA5, "mode_ptr");
        wr(8'h10, 8'h3C);
        `CHK("b_mode_first", 8'h3C, ctl_b.mode_first)
        rd(8'h28);
        `CHK("unmapped", UCC_RESP_SLVERR, r)
        wr(8'h28, 8'h00);
        `CHK("unmapped_wr", UCC_RESP_SLVERR, r)
        $display("test mode pointer done");
        wr(8'h04, 8'hEE);
        wr(8'h14, 8'hEF);
        `CHK("a_ext", 3'b110, {ctl_a.rx_ext, ctl_a.tx_ext, ctl_a.rx_x1})
        `CHK("b_ext", 3'b111, {ctl_b.rx_ext, ctl_b.tx_ext, ctl_b.tx_x1})
        wr(8'h04, 8'hF0);
        // the receiver already takes its clock from the pin, so no divider tick can land on this edge
        @(negedge aclk);
        g = nt;
        repeat (6) begin
            repeat (4) @(posedge aclk);
            pin[2] <= ~pin[2];
        end
        repeat (6) @(posedge aclk);
        `CHK("ext_ticks", 3, nt - g)
        wr(8'h04, 8'h10);
        gap(g);
        `CHK("gap_set0", int'(UCC_DIV_BASE0) * 2, g)
        wr(8'h20, 8'h80);
        gap(g);
        `CHK("gap_set1", int'(UCC_DIV_BASE1) * 2, g)
        wr(8'h04, 8'h00);
        $display("test clock select done");
        wr(8'h08, 8'h05);
        `CHK("enables", 2'b11, {ctl_a.tx_en, ctl_a.rx_en})
        rc(8'h0C, 8'h0C, "status_tx");
        wr(8'h08, 8'h02);
        `CHK("rx_dis", 1'b0, ctl_a.rx_en)
        wr(8'h08, 8'h01);
        wr(8'h08, 8'h20);
        `CHK("rx_rst", 1'b0, ctl_a.rx_en)
        busy <= 1'b1;
        wr(8'h08, 8'h08);
        `CHK("tx_dis_wait", 1'b1, ctl_a.tx_en)
        busy <= 1'b0;
        repeat (4) @(posedge aclk);
        `CHK("tx_dis", 1'b0, ctl_a.tx_en)
        wr(8'h08, 8'h04);
        wr(8'h08, 8'h30);
        `CHK("tx_rst", 1'b0, ctl_a.tx_en)
        rc(8'h0C, 8'h00, "status_tx");
        err <= 4'hF;
        brk <= 1'b1;
        @(posedge aclk);
        err <= 4'h0;
        brk <= 1'b0;
        rc(8'h0C, 8'hF0, "errs");
        rc(8'h24, 8'h04, "irq");
        wr(8'h08, 8'h40);
        rc(8'h0C, 8'h00, "errs_clr");
        wr(8'h08, 8'h50);
        rc(8'h24, 8'h00, "irq_clr");
        $display("test commands done");
        wr(8'h08, 8'h04);
        wr(8'h08, 8'h60);
        `CHK("brk_delay", 1'b0, ctl_a.tx_break)
        g = 0;
        while (!ctl_a.tx_break && g < 200) begin
            @(negedge aclk);
            g++;
        end
        `CHK("brk_on", 1'b1, ctl_a.tx_break)
        wr(8'h08, 8'h70);
        `CHK("brk_off", 2'b01, {ctl_a.tx_break, ctl_a.tx_mark_hold})
        $display("test break done");
        summarize();
    end
endmodule
bind ucc_top ucc_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .ctl_a(ctl_a), .ctl_b(ctl_b));
`default_nettype wire
